// File: common/sgs_consts.svh
// offsets, field positions, reset values and widths of the setting group selector
`ifndef SGS_CONSTS_SVH
`define SGS_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the apb bus)
// ----------------------------------------------------------------------
`define SGS_ADDR_W 8
`define SGS_OFS_USED 8'h00
`define SGS_OFS_FORCE_EN 8'h04
`define SGS_OFS_FORCE_SEL 8'h08
`define SGS_OFS_REMOTE 8'h0C
`define SGS_OFS_LOCAL 8'h10
`define SGS_OFS_STATUS 8'h14
`define SGS_OFS_EVT_ON 8'h18
`define SGS_OFS_EVT_OFF 8'h1C
`define SGS_OFS_MASK_ON 8'h20
`define SGS_OFS_MASK_OFF 8'h24

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define SGS_GROUPS 8
`define SGS_CODE_W 4
`define SGS_CODE_NONE 4'h0
`define SGS_CODE_MAX 4'h8
`define SGS_USED_RST 8'h01
`define SGS_STAT_REQ_LSB 8
`define SGS_STAT_FORCE_BIT 16
`define SGS_EVT_W 29
`define SGS_EVT_LEVEL_RST 29'h0000001
`define SGS_EVT_RST 29'h0000000

`endif

// File: common/sgs_pkg.sv
// types shared by the setting group selector files
package sgs_pkg;

  // ----------------------------------------------------------------------
  // event source levels; bit 0 is group 1 active
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic fail_lowp;
    logic fail_force;
    logic fail_ncfg;
    logic force_on;
    logic local_req;
    logic remote_req;
    logic [7:0] request;
    logic [6:0] enabled;
    logic [7:0] active;
  } sgs_evt_type;

  // ----------------------------------------------------------------------
  // state of the selector, apart from the event edge registers in sgs_edge_event
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] req_meta;
    logic [7:0] req_sync;
    logic [2:0] active;
    logic [7:0] used;
    logic force_en;
    logic [3:0] force_code;
    logic [3:0] remote_code;
    logic [3:0] local_code;
    logic force_pend;
    logic remote_pend;
    logic local_pend;
    logic fail_ncfg;
    logic fail_force;
    logic fail_lowp;
    logic [28:0] evt_on;
    logic [28:0] evt_off;
    logic [28:0] mask_on;
    logic [28:0] mask_off;
    logic [7:0] active_onehot;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sgs_state_type;

endpackage

// File: rtl/sgs_edge_event.sv
// turns a vector of levels into registered on and off event pulses
`timescale 1ns/100ps
module sgs_edge_event #(
  parameter int W = 29,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels watched
  input wire logic [W-1:0] level,
  // one-cycle pulses
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } sgs_edge_state_type;

  sgs_edge_state_type st;
  sgs_edge_state_type next_st;

  // compare each level with its last value
  always_comb
  begin
    next_st = st;
    next_st.prev = level;
    next_st.rise = level & ~st.prev;
    next_st.fall = ~level & st.prev;
  end

  // prev starts at the reset pattern so reset itself raises nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '{prev: RST, rise: '0, fall: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
  assign fall = st.fall;

endmodule

// File: rtl/sgs_selector.sv
// setting group selector: priority resolution, events, apb registers
//
// Functional notes
// RQ1 - The active group is kept after its request goes away and returns to group 1 only on request.
// RQ2 - In one-wire coil control the outside logic requests group 1 with coil on and group 2 off.
// RQ3 - With group 2 held and group 1 asserted briefly, group 1 is active then group 2 again.
// RQ4 - Active on/off events exist per group, and enabled/disabled events for groups 2 to 8.
// RQ5 - Request on/off events exist per group input and for the remote and local change requests.
// RQ6 - A request to a group not marked used is rejected with a not-configured fail event.
// RQ7 - A request blocked by a held higher-priority request gives a lower-priority fail event.
// RQ8 - Force on/off raises events, and a forced selection without force enabled fails.
// RQ9 - Each group request input accepts any logic combination built outside the selector.
// RQ10 - Group 1 has highest priority and group 8 lowest; a held request blocks lower ones.
// RQ11 - A remote change code 0 means none, 1 to 8 a group, and it cannot beat a held higher group; with force enabled the code skips this check.
// RQ12 - While force is enabled the forced selection overrides local control until disabled.
// RQ13 - A failed request leaves the active group unchanged and only updates its fail event.
`timescale 1ns/100ps
`include "sgs_consts.svh"
module sgs_selector (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // group request inputs, any combination built outside
  input wire logic [7:0] group_req,
  // selection result
  output logic [2:0] active_group,
  output logic [7:0] group_active,
  // interrupt
  output logic irq
);
  import sgs_pkg::*;

  // ----------------------------------------------------------------------
  // state and event plumbing
  // ----------------------------------------------------------------------
  sgs_state_type st;
  sgs_state_type next_st;
  sgs_evt_type evt_level;
  logic [`SGS_EVT_W-1:0] evt_rise;
  logic [`SGS_EVT_W-1:0] evt_fall;

  // event source levels taken from registered state
  always_comb
  begin
    evt_level.active = st.active_onehot; // RQ4
    evt_level.enabled = st.used[7:1]; // RQ4
    evt_level.request = st.req_sync; // RQ5
    evt_level.remote_req = st.remote_pend; // RQ5
    evt_level.local_req = st.local_pend; // RQ5
    evt_level.force_on = st.force_en; // RQ8
    evt_level.fail_ncfg = st.fail_ncfg; // RQ6
    evt_level.fail_force = st.fail_force; // RQ8
    evt_level.fail_lowp = st.fail_lowp; // RQ7
  end

  // rising edge gives the on event, falling edge the off event
  sgs_edge_event #(
    .W(`SGS_EVT_W),
    .RST(`SGS_EVT_LEVEL_RST)
  ) sgs_edge_event_inst (
    .pclk(pclk),
    .presetn(presetn),
    .level(evt_level),
    .rise(evt_rise),
    .fall(evt_fall)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic any_held;
    logic [2:0] hp;
    logic cand_ok;
    logic [2:0] cand;
    logic [3:0] rcode;
    logic [2:0] ridx;
    logic [3:0] lcode;
    logic [2:0] lidx;
    logic [3:0] fcode;
    logic [7:0] ofs;
    logic wr;
    logic [31:0] rd;
    logic mapped;
    logic [28:0] clr_on;
    logic [28:0] clr_off;
    any_held = 1'b0;
    hp = 3'h0;
    cand_ok = 1'b0;
    cand = 3'h0;
    rcode = st.remote_code;
    ridx = 3'(rcode - 4'h1);
    lcode = st.local_code;
    lidx = 3'(lcode - 4'h1);
    fcode = st.force_code;
    ofs = paddr[7:0];
    wr = 1'b0;
    rd = 32'h0000_0000;
    mapped = 1'b1;
    clr_on = '0;
    clr_off = '0;
    next_st = st;

    // two-flop synchroniser for the request pins
    next_st.req_meta = group_req; // RQ9
    next_st.req_sync = st.req_meta;

    // pending requests last one processing cycle; fail levels clear each cycle unless set again
    next_st.force_pend = 1'b0;
    next_st.remote_pend = 1'b0;
    next_st.local_pend = 1'b0;
    next_st.fail_ncfg = 1'b0;
    next_st.fail_force = 1'b0;
    next_st.fail_lowp = 1'b0;

    // highest-priority held input, group 1 first
    for (int i = `SGS_GROUPS - 1; i >= 0; i--)
    begin
      if (st.req_sync[i])
      begin
        any_held = 1'b1; // RQ10
        hp = 3'(i); // RQ10
      end
    end

    if (st.force_en)
    begin
      // force overrides inputs and local changes until disabled
      if (st.force_pend && fcode != `SGS_CODE_NONE && fcode <= `SGS_CODE_MAX) // RQ12
      begin
        cand_ok = 1'b1;
        cand = 3'(fcode - 4'h1);
      end
      else if (st.remote_pend && rcode != `SGS_CODE_NONE && rcode <= `SGS_CODE_MAX) // RQ11
      begin
        cand_ok = 1'b1;
        cand = ridx;
      end
    end
    else
    begin
      // forced selection tried while not permitted
      if (st.force_pend)
      begin
        next_st.fail_force = 1'b1; // RQ8
      end
      // held requests below the winner are refused
      for (int i = 0; i < `SGS_GROUPS; i++)
      begin
        if (any_held && st.req_sync[i] && 3'(i) > hp)
        begin
          next_st.fail_lowp = 1'b1; // RQ7 RQ10
        end
      end
      if (any_held)
      begin
        cand_ok = 1'b1; // RQ3 RQ10
        cand = hp;
      end
      // remote change, blocked by a higher held group
      if (st.remote_pend && rcode != `SGS_CODE_NONE && rcode <= `SGS_CODE_MAX)
      begin
        if (any_held && ridx > hp)
        begin
          next_st.fail_lowp = 1'b1; // RQ11 RQ7
        end
        else
        begin
          cand_ok = 1'b1; // RQ11
          cand = ridx;
        end
      end
      // local change, lowest precedence of the sources
      else if (st.local_pend && lcode != `SGS_CODE_NONE && lcode <= `SGS_CODE_MAX)
      begin
        if (any_held && lidx > hp)
        begin
          next_st.fail_lowp = 1'b1; // RQ7
        end
        else
        begin
          cand_ok = 1'b1;
          cand = lidx;
        end
      end
    end

    // apply the winner; no winner keeps the group as it is
    if (cand_ok)
    begin
      if (st.used[cand])
      begin
        next_st.active = cand; // RQ1 RQ3
      end
      else
      begin
        next_st.fail_ncfg = 1'b1; // RQ6 RQ13
      end
    end

    // apb: one wait cycle, then pready for one cycle
    if (psel && penable && !st.pready)
    begin
      case (ofs)
        `SGS_OFS_USED: rd = {24'h000000, st.used};
        `SGS_OFS_FORCE_EN: rd = {31'h00000000, st.force_en};
        `SGS_OFS_FORCE_SEL: rd = {28'h0000000, st.force_code};
        `SGS_OFS_REMOTE: rd = {28'h0000000, st.remote_code};
        `SGS_OFS_LOCAL: rd = {28'h0000000, st.local_code};
        `SGS_OFS_STATUS:
        begin
          rd[2:0] = st.active;
          rd[`SGS_STAT_REQ_LSB +: 8] = st.req_sync;
          rd[`SGS_STAT_FORCE_BIT] = st.force_en;
        end
        `SGS_OFS_EVT_ON: rd = {3'h0, st.evt_on};
        `SGS_OFS_EVT_OFF: rd = {3'h0, st.evt_off};
        `SGS_OFS_MASK_ON: rd = {3'h0, st.mask_on};
        `SGS_OFS_MASK_OFF: rd = {3'h0, st.mask_off};
        default: mapped = 1'b0;
      endcase
      next_st.pready = 1'b1;
      next_st.pslverr = ~mapped;
      next_st.prdata = pwrite ? 32'h0000_0000 : rd;
    end
    else
    begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
    end

    // writes take effect at the edge that samples pready high
    wr = psel && penable && pwrite && st.pready && !st.pslverr;
    if (wr)
    begin
      case (ofs)
        `SGS_OFS_USED: next_st.used = {pwdata[7:1], 1'b1};
        `SGS_OFS_FORCE_EN: next_st.force_en = pwdata[0];
        `SGS_OFS_FORCE_SEL:
        begin
          next_st.force_code = pwdata[3:0];
          next_st.force_pend = (pwdata[3:0] != `SGS_CODE_NONE); // RQ8
        end
        `SGS_OFS_REMOTE:
        begin
          next_st.remote_code = pwdata[3:0];
          next_st.remote_pend = (pwdata[3:0] != `SGS_CODE_NONE); // RQ11
        end
        `SGS_OFS_LOCAL:
        begin
          next_st.local_code = pwdata[3:0];
          next_st.local_pend = (pwdata[3:0] != `SGS_CODE_NONE) && !st.force_en; // RQ12
        end
        `SGS_OFS_EVT_ON: clr_on = pwdata[28:0];
        `SGS_OFS_EVT_OFF: clr_off = pwdata[28:0];
        `SGS_OFS_MASK_ON: next_st.mask_on = pwdata[28:0];
        `SGS_OFS_MASK_OFF: next_st.mask_off = pwdata[28:0];
        default: next_st.mask_on = st.mask_on;
      endcase
    end

    // sticky events, a new event wins over a same-cycle clear
    next_st.evt_on = (st.evt_on & ~clr_on) | evt_rise;
    next_st.evt_off = (st.evt_off & ~clr_off) | evt_fall;
    next_st.irq = |((next_st.evt_on & next_st.mask_on) | (next_st.evt_off & next_st.mask_off));

    // one-hot copy of the active group
    for (int i = 0; i < `SGS_GROUPS; i++)
    begin
      next_st.active_onehot[i] = (next_st.active == 3'(i));
    end
  end

  // ----------------------------------------------------------------------
  // state register; group 1 active after reset
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '{
        req_meta: 8'h00,
        req_sync: 8'h00,
        active: 3'h0,
        used: `SGS_USED_RST,
        force_en: 1'b0,
        force_code: `SGS_CODE_NONE,
        remote_code: `SGS_CODE_NONE,
        local_code: `SGS_CODE_NONE,
        force_pend: 1'b0,
        remote_pend: 1'b0,
        local_pend: 1'b0,
        fail_ncfg: 1'b0,
        fail_force: 1'b0,
        fail_lowp: 1'b0,
        evt_on: `SGS_EVT_RST,
        evt_off: `SGS_EVT_RST,
        mask_on: `SGS_EVT_RST,
        mask_off: `SGS_EVT_RST,
        active_onehot: 8'h01,
        irq: 1'b0,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
      };
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign active_group = st.active;
  assign group_active = st.active_onehot;
  assign irq = st.irq;

endmodule

// File: dv/sgs_checker.sv
// port assertions for the setting group selector
`timescale 1ns/100ps
module sgs_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // group side
  input wire logic [7:0] group_req,
  input wire logic [2:0] active_group,
  input wire logic [7:0] group_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------------
  // steps of an access, of a quiet stretch and of held requests
  // ----------------------------------------------------------------------
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_quiet; (group_req == 8'h00 && !psel) [*6]; endsequence
  sequence s_hold1; group_req[0] [*4]; endsequence
  sequence s_hold2; (group_req[1:0] == 2'b10) [*4]; endsequence

  // ----------------------------------------------------------------------
  // bus answer and group selection
  // ----------------------------------------------------------------------
  a_one_wait: assert property (s_access |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_data: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not zero outside answer");
  a_err_answer: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("pslverr without pready or with data");
  a_onehot_match: assert property (group_active == (8'h01 << active_group))
    else $error("one-hot does not match index");
  a_group_kept: assert property (s_quiet |-> $stable(active_group))
    else $error("group changed with no request");
  a_top_wins: assert property (s_hold1 |-> active_group == 3'h0)
    else $error("held group 1 not active");
  a_second_held: assert property (s_hold2 |-> active_group == 3'h1)
    else $error("held group 2 not active");
endmodule

bind sgs_selector sgs_checker sgs_checker_inst (.pclk, .presetn, .psel, .penable, .prdata,
  .pready, .pslverr, .group_req, .active_group, .group_active);

// File: dv/sgs_relay_logic.sv
// relay logic model that builds the group request levels
`timescale 1ns/100ps
module sgs_relay_logic (
  // controls from the bench
  input wire logic en,
  input wire logic coil,
  input wire logic boost,
  input wire logic cold,
  input wire logic [4:0] extra,
  // request levels
  output logic [7:0] group_req
);
  // coil on asks group 1, coil off or a broken wire asks group 2
  assign group_req[0] = en & (coil | boost);
  assign group_req[1] = en & ~coil;
  // cold load pickup gated by the coil logic being off
  assign group_req[2] = cold & ~en;
  assign group_req[7:3] = extra;
endmodule

// File: dv/sgs_selector_tb.sv
// self-checking bench for the setting group selector
`timescale 1ns/100ps
`include "sgs_consts.svh"
module sgs_selector_tb;
  import sgs_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [7:0] group_req, group_active;
  logic [2:0] active_group;
  logic en, coil, boost, cold;
  logic [4:0] extra;
  int errors;
  int compares;

  // 25 MHz clock
  always #20 pclk = ~pclk;

  sgs_selector sgs_selector_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .group_req, .active_group, .group_active, .irq);
  sgs_relay_logic sgs_relay_logic_inst (.en, .coil, .boost, .cold, .extra, .group_req);

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer, answer taken at the edge that samples pready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready is read right after each rising edge, so it is the value sampled there
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    xfer(1'b0, a, 32'h00000000);
    chk($sformatf("reg %h", a), exp, q & m);
  endtask

  // let requests settle, then check the selected group
  task grp(input logic [2:0] g);
    repeat (8) @(negedge pclk);
    chk("active_group", {29'h0, g}, {29'h0, active_group});
    chk("group_active", {24'h0, 8'h01 << g}, {24'h0, group_active});
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done;
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    errors = 0;
    compares = 0;
    {presetn, psel, penable, pwrite, en, coil, boost, cold} = 8'h00;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    extra = 5'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SGS_OFS_USED, 32'h00000001, 32'hFFFFFFFF);
    rd(8'h40, 32'h00000000, 32'hFFFFFFFF);
    chk("pslverr", 32'h1, {31'h0, e});
    wr(`SGS_OFS_MASK_OFF, 32'h00000000);
    wr(`SGS_OFS_MASK_ON, 32'h1FFFFFFF);
    wr(`SGS_OFS_USED, 32'h000000FF);
    rd(`SGS_OFS_EVT_ON, 32'h00007F00, 32'h00007F00);
    // coil control and a short group 1 request over held group 2
    en <= 1'b1;
    coil <= 1'b1;
    grp(3'h0);
    coil <= 1'b0;
    grp(3'h1);
    boost <= 1'b1;
    grp(3'h0);
    boost <= 1'b0;
    grp(3'h1);
    rd(`SGS_OFS_STATUS, 32'h00000201, 32'h0000FF07);
    // lower requests under held group 2, stale fail event cleared first
    wr(`SGS_OFS_EVT_ON, 32'h10000000);
    extra <= 5'h01;
    grp(3'h1);
    rd(`SGS_OFS_EVT_ON, 32'h10000000, 32'h10000000);
    extra <= 5'h00;
    wr(`SGS_OFS_REMOTE, 32'h00000004);
    grp(3'h1);
    en <= 1'b0;
    grp(3'h1);
    cold <= 1'b1;
    grp(3'h2);
    cold <= 1'b0;
    grp(3'h2);
    // pulsed requests of groups 4 to 8 each stay after release
    for (int i = 0; i < 5; i++)
    begin
      extra <= 5'h01 << i;
      grp(3'(3 + i));
      extra <= 5'h00;
      grp(3'(3 + i));
    end
    rd(`SGS_OFS_EVT_ON, 32'h007F80FF, 32'h007F80FF);
    wr(`SGS_OFS_REMOTE, 32'h00000001);
    grp(3'h0);
    wr(`SGS_OFS_LOCAL, 32'h00000002);
    grp(3'h1);
    rd(`SGS_OFS_EVT_ON, 32'h01800000, 32'h01800000);
    // unused group refused
    wr(`SGS_OFS_USED, 32'h00000003);
    wr(`SGS_OFS_REMOTE, 32'h00000005);
    grp(3'h1);
    rd(`SGS_OFS_EVT_ON, 32'h04000000, 32'h04000000);
    rd(`SGS_OFS_EVT_OFF, 32'h00007E00, 32'h00007E00);
    // force selection
    wr(`SGS_OFS_FORCE_SEL, 32'h00000002);
    grp(3'h1);
    rd(`SGS_OFS_EVT_ON, 32'h08000000, 32'h08000000);
    wr(`SGS_OFS_FORCE_EN, 32'h00000001);
    wr(`SGS_OFS_FORCE_SEL, 32'h00000001);
    grp(3'h0);
    wr(`SGS_OFS_LOCAL, 32'h00000002);
    grp(3'h0);
    rd(`SGS_OFS_STATUS, 32'h00010000, 32'h0001FF07);
    wr(`SGS_OFS_FORCE_EN, 32'h00000000);
    rd(`SGS_OFS_EVT_ON, 32'h02000000, 32'h02000000);
    rd(`SGS_OFS_EVT_OFF, 32'h02000000, 32'h02000000);
    // interrupt raised, masked, cleared
    chk("irq", 32'h1, {31'h0, irq});
    wr(`SGS_OFS_MASK_ON, 32'h00000000);
    repeat (4) @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`SGS_OFS_MASK_ON, 32'h1FFFFFFF);
    wr(`SGS_OFS_EVT_ON, 32'h1FFFFFFF);
    rd(`SGS_OFS_EVT_ON, 32'h00000000, 32'hFFFFFFFF);
    chk("irq", 32'h0, {31'h0, irq});
    test_done;
  end
endmodule
